// *** core/dpra_pkg.sv ***
package dpra_pkg;
  localparam int DATA_W       = 32;
  localparam int REG_A_W      = 2;
  localparam int BANK_SEL_W   = 4;
  localparam int AP_ADDR_W    = 64;
  localparam int SEL_LO_W     = 28;
  localparam int SEL_HI_W     = 32;
  localparam int SEL_LO_LSB   = 4;
  // debug-port register indices at a[3:2]
  localparam logic [1:0] DP_A_SELECT  = 2'h2;
  localparam logic [1:0] DP_A_AP_SELECTION_HIGH_REG = 2'h1;
  localparam logic [3:0] DP_BANK_SEL1 = 4'h5;
  localparam logic [1:0] WORD_ALIGN   = 2'h0;
  localparam logic [BANK_SEL_W-1:0] BANK_SEL_RST = 4'h0;
  localparam logic [SEL_LO_W-1:0]   SEL_LO_RST   = 28'h0;
  localparam logic [SEL_HI_W-1:0]   SEL_HI_RST   = 32'h0;
endpackage

// *** core/dpra_link_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// toggle-handshake carrying one request word from the link clock to sys_clk
module dpra_link_sync
  import dpra_pkg::*;
#(
  parameter int W = 36
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] link_word,
  input  wire logic         link_tog,
  output logic              sys_pulse,
  output logic [W-1:0]      sys_word
);
  logic [2:0]   tog_sync_q;
  logic [2:0]   tog_sync_d;
  logic         pulse_q;
  logic         pulse_d;
  logic [W-1:0] word_q;
  logic [W-1:0] word_d;

  always_comb begin
    tog_sync_d = {tog_sync_q[1:0], link_tog};
    pulse_d    = tog_sync_q[2] ^ tog_sync_q[1];
    word_d     = word_q;
    // word held stable by the link side until the next toggle
    if (tog_sync_q[2] ^ tog_sync_q[1]) begin
      word_d = link_word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tog_sync_q <= 3'h0;
      pulse_q    <= 1'h0;
      word_q     <= '0;
    end else begin
      tog_sync_q <= tog_sync_d;
      pulse_q    <= pulse_d;
      word_q     <= word_d;
    end
  end

  assign sys_pulse = pulse_q;
  assign sys_word  = word_q;
endmodule
`default_nettype wire

// *** core/dpra_addr_core.sv ***
`timescale 1ns/1ns
`default_nettype none
// Function
// - every transfer carries 32 data bits
// - split requests into port and access-port classes
// - port register picked by a[3:2] and bank
// - high and low fields form 60-bit bank
// - generated addresses have low two bits zero
// - access-port address recomputed per request
// - four bank registers reachable by a[3:2]
// - single debug port owns the link
// - one or more access ports share space
// - shared memory port needs lookup table
module dpra_addr_core
  import dpra_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  link_clk,
  input  wire logic                  link_rst,
  input  wire logic                  link_req,
  input  wire logic                  link_is_ap,
  input  wire logic                  link_wr,
  input  wire logic [REG_A_W-1:0]    link_a,
  input  wire logic [DATA_W-1:0]     link_wdata,
  output logic                       dp_req,
  output logic                       dp_wr,
  output logic [BANK_SEL_W-1:0]      dp_reg_bank,
  output logic [REG_A_W-1:0]         dp_reg_a,
  output logic [DATA_W-1:0]          dp_wdata,
  output logic                       ap_req,
  output logic                       ap_wr,
  output logic [AP_ADDR_W-1:0]       ap_addr,
  output logic [DATA_W-1:0]          ap_wdata,
  output logic [BANK_SEL_W-1:0]      dp_bank_select_field,
  output logic [SEL_HI_W-1:0]        ap_bank_address_high
);
  localparam int RW = DATA_W + REG_A_W + 2;

  function automatic logic [AP_ADDR_W-1:0] ap_reg_addr(
    input logic [SEL_HI_W-1:0] hi,
    input logic [SEL_LO_W-1:0] lo,
    input logic [REG_A_W-1:0]  a
  );
    ap_reg_addr = {hi, lo, a, WORD_ALIGN};
  endfunction

  // link domain: capture one request per link_req pulse
  logic [RW-1:0] lword_q;
  logic [RW-1:0] lword_d;
  logic          ltog_q;
  logic          ltog_d;

  always_comb begin
    lword_d = lword_q;
    ltog_d  = ltog_q;
    if (link_req) begin
      lword_d = {link_is_ap, link_wr, link_a, link_wdata};
      ltog_d  = ~ltog_q;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lword_q <= '0;
      ltog_q  <= 1'h0;
    end else begin
      lword_q <= lword_d;
      ltog_q  <= ltog_d;
    end
  end

  logic          rq_v;
  logic [RW-1:0] rq_w;

  dpra_link_sync #(
    .W (RW)
  ) u_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .link_word (lword_q),
    .link_tog  (ltog_q),
    .sys_pulse (rq_v),
    .sys_word  (rq_w)
  );

  logic                  rq_ap;
  logic                  rq_wr;
  logic [REG_A_W-1:0]    rq_a;
  logic [DATA_W-1:0]     rq_data;
  assign {rq_ap, rq_wr, rq_a, rq_data} = rq_w;

  logic [BANK_SEL_W-1:0] bank_q;
  logic [BANK_SEL_W-1:0] bank_d;
  logic [SEL_LO_W-1:0]   sel_lo_q;
  logic [SEL_LO_W-1:0]   sel_lo_d;
  logic [SEL_HI_W-1:0]   sel_hi_q;
  logic [SEL_HI_W-1:0]   sel_hi_d;
  logic                  sel_lo_hit;
  logic                  sel_hi_hit;

  // selection fields decoded here, honoured by the next request
  always_comb begin
    sel_lo_hit = rq_v && !rq_ap && rq_wr && (rq_a == DP_A_SELECT);
    sel_hi_hit = rq_v && !rq_ap && rq_wr && (rq_a == DP_A_AP_SELECTION_HIGH_REG) && (bank_q == DP_BANK_SEL1);
    bank_d     = bank_q;
    sel_lo_d   = sel_lo_q;
    sel_hi_d   = sel_hi_q;
    if (sel_lo_hit) begin
      bank_d   = rq_data[BANK_SEL_W-1:0];
      sel_lo_d = rq_data[DATA_W-1:SEL_LO_LSB];
    end
    if (sel_hi_hit) begin
      sel_hi_d = rq_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bank_q   <= BANK_SEL_RST;
      sel_lo_q <= SEL_LO_RST;
      sel_hi_q <= SEL_HI_RST;
    end else begin
      bank_q   <= bank_d;
      sel_lo_q <= sel_lo_d;
      sel_hi_q <= sel_hi_d;
    end
  end

  logic                  dp_req_q;
  logic                  dp_req_d;
  logic                  dp_wr_q;
  logic                  dp_wr_d;
  logic [BANK_SEL_W-1:0] dp_bank_q;
  logic [BANK_SEL_W-1:0] dp_bank_d;
  logic [REG_A_W-1:0]    dp_a_q;
  logic [REG_A_W-1:0]    dp_a_d;
  logic [DATA_W-1:0]     dp_wd_q;
  logic [DATA_W-1:0]     dp_wd_d;

  always_comb begin
    dp_req_d  = 1'h0;
    dp_wr_d   = dp_wr_q;
    dp_bank_d = dp_bank_q;
    dp_a_d    = dp_a_q;
    dp_wd_d   = dp_wd_q;
    if (rq_v && !rq_ap) begin
      dp_req_d  = 1'h1;
      dp_wr_d   = rq_wr;
      dp_wd_d   = rq_data;
      dp_a_d    = rq_a;
      dp_bank_d = bank_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dp_req_q  <= 1'h0;
      dp_wr_q   <= 1'h0;
      dp_bank_q <= '0;
      dp_a_q    <= '0;
      dp_wd_q   <= '0;
    end else begin
      dp_req_q  <= dp_req_d;
      dp_wr_q   <= dp_wr_d;
      dp_bank_q <= dp_bank_d;
      dp_a_q    <= dp_a_d;
      dp_wd_q   <= dp_wd_d;
    end
  end

  logic                  ap_req_q;
  logic                  ap_req_d;
  logic                  ap_wr_q;
  logic                  ap_wr_d;
  logic [AP_ADDR_W-1:0]  ap_addr_q;
  logic [AP_ADDR_W-1:0]  ap_addr_d;
  logic [DATA_W-1:0]     ap_wd_q;
  logic [DATA_W-1:0]     ap_wd_d;

  always_comb begin
    ap_req_d  = 1'h0;
    ap_wr_d   = ap_wr_q;
    ap_addr_d = ap_addr_q;
    ap_wd_d   = ap_wd_q;
    if (rq_v && rq_ap) begin
      ap_req_d  = 1'h1;
      ap_wr_d   = rq_wr;
      ap_wd_d   = rq_data;
      ap_addr_d = ap_reg_addr(sel_hi_q, sel_lo_q, rq_a);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ap_req_q  <= 1'h0;
      ap_wr_q   <= 1'h0;
      ap_addr_q <= '0;
      ap_wd_q   <= '0;
    end else begin
      ap_req_q  <= ap_req_d;
      ap_wr_q   <= ap_wr_d;
      ap_addr_q <= ap_addr_d;
      ap_wd_q   <= ap_wd_d;
    end
  end

  // lookup tables behind a shared memory port sit in ap_addr space
  // the single link entry point for all access ports
  assign dp_req               = dp_req_q;
  assign dp_wr                = dp_wr_q;
  assign dp_reg_bank          = dp_bank_q;
  assign dp_reg_a             = dp_a_q;
  assign dp_wdata             = dp_wd_q;
  assign ap_req               = ap_req_q;
  assign ap_wr                = ap_wr_q;
  assign ap_addr              = ap_addr_q;
  assign ap_wdata             = ap_wd_q;
  assign dp_bank_select_field = bank_q;
  assign ap_bank_address_high = sel_hi_q;
endmodule
`default_nettype wire

// *** dv/dpra_addr_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpra_addr_checker
  import dpra_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  link_req,
  input wire logic                  dp_req,
  input wire logic                  dp_wr,
  input wire logic [BANK_SEL_W-1:0] dp_reg_bank,
  input wire logic [REG_A_W-1:0]    dp_reg_a,
  input wire logic [DATA_W-1:0]     dp_wdata,
  input wire logic                  ap_req,
  input wire logic [AP_ADDR_W-1:0]  ap_addr,
  input wire logic [BANK_SEL_W-1:0] dp_bank_select_field,
  input wire logic [SEL_HI_W-1:0]   ap_bank_address_high
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_answer;
    ##[1:30] (dp_req || ap_req);
  endsequence
  a_ap_align: assert property (ap_req |-> ap_addr[1:0] == WORD_ALIGN) else $error("ap addr misaligned");
  a_ap_high_join: assert property (ap_req |-> ap_addr[63:32] == ap_bank_address_high) else $error("ap high");
  a_req_excl: assert property (!(dp_req && ap_req)) else $error("both classes at once");
  a_req_answer: assert property ($rose(link_req) |-> s_answer) else $error("no answer");
  a_ap_hold: assert property (!ap_req |-> $stable(ap_addr)) else $error("ap addr moved");
  a_dp_hold: assert property (!dp_req |-> $stable({dp_wr, dp_reg_bank, dp_reg_a, dp_wdata}))
    else $error("dp moved");
  a_hi_cause: assert property ($changed(ap_bank_address_high) |->
    dp_req && dp_wr && dp_reg_a == DP_A_AP_SELECTION_HIGH_REG && dp_reg_bank == DP_BANK_SEL1) else $error("high field cause");
  a_bank_cause: assert property ($changed(dp_bank_select_field) |->
    dp_req && dp_wr && dp_reg_a == DP_A_SELECT) else $error("bank field cause");
endmodule
bind dpra_addr_core dpra_addr_checker u_dpra_addr_checker (.*);
`default_nettype wire

// *** dv/dpra_dbg_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpra_dbg_model (
  input wire logic    link_clk,
  output logic        link_req,
  output logic        link_is_ap,
  output logic        link_wr,
  output logic [1:0]  link_a,
  output logic [31:0] link_wdata
);
  initial {link_req, link_is_ap, link_wr, link_a, link_wdata} = '0;
  // lines are inverted after release so stale values never look valid
  task automatic send(input logic ap, wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge link_clk);
    {link_req, link_is_ap, link_wr, link_a, link_wdata} <= {1'h1, ap, wr, a, d};
    @(posedge link_clk);
    {link_req, link_is_ap, link_wr, link_a, link_wdata} <= {1'h0, ~ap, ~wr, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb import dpra_pkg::*;;
  logic                  sys_clk, rst, link_clk, link_rst, link_req, link_is_ap, link_wr;
  logic                  dp_req, dp_wr, ap_req, ap_wr;
  logic [REG_A_W-1:0]    link_a, dp_reg_a;
  logic [DATA_W-1:0]     link_wdata, dp_wdata, ap_wdata;
  logic [BANK_SEL_W-1:0] dp_reg_bank, dp_bank_select_field, bank;
  logic [AP_ADDR_W-1:0]  ap_addr;
  logic [SEL_HI_W-1:0]   ap_bank_address_high, hi;
  logic [SEL_LO_W-1:0]   lo;
  logic [97:0]           q[$];
  int                    err_total, total_checks, cyc, seed;
  dpra_addr_core u_dpra_addr_core (.*);
  dpra_dbg_model u_dpra_dbg_model (.*);
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'h0;
    #3;
    forever begin
      link_clk = 1'h1;
      #62;
      link_clk = 1'h0;
      #63;
    end
  end
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_dp(input logic [97:0] got);
    logic [97:0] exp;
    exp = q.size() ? q.pop_front() : 'x;
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t dp got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ap(input logic [97:0] got);
    logic [97:0] exp;
    exp = q.size() ? q.pop_front() : 'x;
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t ap got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_drain(input int left);
    total_checks++;
    if (left != 0) begin
      err_total++;
      $display("CHECK FAILED t=%0t left got=%h exp=%h", $time, left, 32'h0);
    end
  endtask
  task automatic op(input logic ap, wr, input logic [1:0] a, input logic [31:0] d);
    logic [BANK_SEL_W-1:0] b0;
    b0 = bank;
    if (!ap && wr && a == DP_A_SELECT) {lo, bank} = d;
    else if (!ap && wr && a == DP_A_AP_SELECTION_HIGH_REG && b0 == DP_BANK_SEL1) hi = d;
    if (ap) q.push_back({1'h1, wr, hi, lo, a, WORD_ALIGN, d});
    else q.push_back({1'h0, wr, 22'h0, bank, hi, b0, a, d});
    u_dpra_dbg_model.send(ap, wr, a, d);
  endtask
  always @(posedge sys_clk) begin
    if (dp_req === 1'h1) begin
      chk_dp({1'h0, dp_wr, 22'h0, dp_bank_select_field, ap_bank_address_high,
              dp_reg_bank, dp_reg_a, dp_wdata});
    end
    if (ap_req === 1'h1) chk_ap({1'h1, ap_wr, ap_addr, ap_wdata});
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    {rst, link_rst} = 2'h3;
    {hi, lo, bank} = {SEL_HI_RST, SEL_LO_RST, BANK_SEL_RST};
    seed = $urandom(27);
    repeat (4) @(posedge sys_clk);
    {rst, link_rst} <= 2'h0;
    repeat (2) @(posedge link_clk);
    for (int k = 0; k < 3; k++) begin
      op(1'h0, 1'h1, DP_A_SELECT, ($urandom & 32'hFFFF_FFF0) | 32'(DP_BANK_SEL1));
      op(1'h0, 1'h1, DP_A_AP_SELECTION_HIGH_REG, $urandom);
      op(1'h0, 1'h1, DP_A_SELECT, $urandom);
      op(1'h0, 1'h1, DP_A_AP_SELECTION_HIGH_REG, $urandom);
      for (int a = 0; a < 4; a++) op(1'h1, 1'($urandom), 2'(a), $urandom);
      op(1'h0, 1'h0, 2'($urandom), $urandom);
    end
    repeat (40) @(posedge sys_clk);
    chk_drain(q.size());
    complete_run();
  end
endmodule
`default_nettype wire
